// *** bdm_regs.svh ***
// Constants for the banked data memory addressing block
//
// Overview of operation
// RL1: Every location uses a 12-bit address.
// RL2: Sixteen 256-byte banks, top nibble selects bank.
// RL3: All banks present, 3808 user bytes.
// RL4: Unimplemented locations read back as zero.
// RL5: Banked address is bank nibble plus operand.
// RL6: Bank selector keeps only low nibble.
// RL7: Literal instruction loads bank selector directly.
// RL8: Dropped writes still update status flags.
// RL9: Full move uses two 12-bit addresses.
// RL10: Other instructions use banked or access map.
// RL11: Access map joins bank 0 low, bank 15 high.
// RL12: Select bit one uses bank selector.
// RL13: Select bit zero forces access map.
// RL14: Access operand completes in one cycle.
// RL15: Extended mode alters map, handled elsewhere.
// RL16: User RAM starts at address zero.
// RL17: User RAM never cleared by reset.
// RL18: Bank 15 offset F9h hits program counter low.
// RL19: Control registers occupy F60h to FFFh.
// RL20: Operand read in Q2, write in Q4.
// RL21: Access address is offset or F00h plus offset.
`ifndef BDM_REGS_SVH
`define BDM_REGS_SVH

`define BDM_ADDR_W      12
`define BDM_DEPTH       4096
`define BDM_BANK_W      4
`define BDM_OFS_W       8
`define BDM_RAM_TOP     12'hF5F
`define BDM_CTRL_BASE   12'hF60
`define BDM_ACC_SPLIT   8'h60
`define BDM_ACC_HIGH    4'hF
`define BDM_ACC_LOW     4'h0
`define BDM_BSEL_ADDR   12'hFE0
`define BDM_PCL_OFS     8'hF9
`define BDM_EXT_LO      12'hE80
`define BDM_EXT_HI      12'hEFF
`define BDM_PCL_BANK    4'hF
`define BDM_BSEL_RST    4'h0
`define BDM_ZERO_BYTE   8'h00
`define BDM_HI_NIBBLE   4'h0
`define BDM_Q_LAST      2'h3
`define BDM_Q_READ      2'h1
`define BDM_Q_WRITE     2'h3
`define BDM_Q_FIRST     2'h0

`endif

// *** bdm_pkg.sv ***
// Types for the banked data memory addressing block
package bdm_pkg;

    // Kinds of data access an instruction may make
    typedef enum logic [1:0] {
        BDM_OP_NONE,
        BDM_OP_FILE,
        BDM_OP_MOVE,
        BDM_OP_LOADBANK
    } bdm_op_t;

    // Quadrature phase within an instruction cycle
    typedef enum logic [1:0] {
        BDM_PH_Q1,
        BDM_PH_Q2,
        BDM_PH_Q3,
        BDM_PH_Q4
    } bdm_phase_t;

    // Request from the execution pipeline, latched at the end of Q4 and held for one instruction cycle
    typedef struct packed {
        bdm_op_t    op;
        logic       access_sel;
        logic [7:0] offset;
        logic [11:0] src_addr;
        logic [11:0] dst_addr;
        logic       write_en;
        logic [7:0] wdata;
        logic [7:0] literal;
    } bdm_req_t;

endpackage

// *** bdm_addr_gen.sv ***
// Effective address generation for one operand
`timescale 1ns/1ps
`include "bdm_regs.svh"

module bdm_addr_gen (
    input  wire logic [3:0]  bank_sel,
    input  wire logic        access_sel,
    input  wire logic        extended_isa_enable,
    input  wire logic [7:0]  offset,
    output logic [11:0]      eff_addr
);

    // ------------------------------------------------------------
    // Address forming
    // ------------------------------------------------------------
    wire logic        acc_low   = offset < `BDM_ACC_SPLIT;
    wire logic [3:0]  acc_bank  = acc_low ? `BDM_ACC_LOW : `BDM_ACC_HIGH;                   // RL11 RL21
    wire logic [11:0] acc_addr  = {acc_bank, offset};                                       // RL13
    wire logic [11:0] bank_addr = {bank_sel, offset};                                       // RL5 RL12
    // Extended mode remap lives outside; here it falls back to plain access map
    wire logic        use_bank  = access_sel;                                               // RL15

    // Select between banked and forced access map
    assign eff_addr = use_bank ? bank_addr : acc_addr;                                      // RL10

    wire logic unused_extended_isa_enable = extended_isa_enable;

endmodule

// *** bdm_data_mem.sv ***
// Banked data memory with bank selector and address generation
`timescale 1ns/1ps
`include "bdm_regs.svh"

module bdm_data_mem (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire bdm_pkg::bdm_req_t req,
    input  wire logic             req_valid,
    input  wire logic             extended_isa_enable,
    output logic [7:0]            rdata,
    output logic [11:0]           rd_addr,
    output logic                  status_update,
    output logic                  write_done,
    output logic                  pcl_write,
    output logic [7:0]            pcl_data,
    output logic [3:0]            bank_select,
    output bdm_pkg::bdm_phase_t   phase
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]  mem_q [0:`BDM_DEPTH-1];                     // RL1 RL3, no reset on contents (RL17)
    logic [3:0]  bank_q;
    logic [1:0]  phase_q;
    bdm_pkg::bdm_req_t req_q;
    logic        act_q;
    logic [7:0]  rdata_q;
    logic [11:0] rd_addr_q;
    logic        stat_q;
    logic        wdone_q;
    logic        pclw_q;
    logic [7:0]  pcld_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [11:0] file_addr;

    bdm_addr_gen u_addr_gen (
        .bank_sel            (bank_q),
        .access_sel          (req_q.access_sel),
        .extended_isa_enable (extended_isa_enable),
        .offset              (req_q.offset),
        .eff_addr            (file_addr)
    );

    wire logic        is_move    = req_q.op == bdm_pkg::BDM_OP_MOVE;
    wire logic        is_file    = req_q.op == bdm_pkg::BDM_OP_FILE;
    wire logic        is_load    = req_q.op == bdm_pkg::BDM_OP_LOADBANK;
    // Full move bypasses the bank selector entirely
    wire logic [11:0] src_addr   = is_move ? req_q.src_addr : file_addr;                    // RL9
    wire logic [11:0] dst_addr   = is_move ? req_q.dst_addr : file_addr;                    // RL9
    wire logic [3:0]  dst_bank   = dst_addr[11:8];                                          // RL2
    wire logic        q_read     = phase_q == `BDM_Q_READ;
    wire logic        q_write    = phase_q == `BDM_Q_WRITE;
    wire logic        q_last     = phase_q == `BDM_Q_LAST;
    wire logic        q_first    = phase_q == `BDM_Q_FIRST;
    wire logic        do_access  = act_q && (is_move || is_file);
    wire logic        do_write   = do_access && (is_move || req_q.write_en);
    // Every bank is present; decode kept for the implemented check
    wire logic        bank_impl  = dst_bank <= `BDM_ACC_HIGH;                               // RL3
    wire logic        src_bsel   = src_addr == `BDM_BSEL_ADDR;
    wire logic        dst_bsel   = dst_addr == `BDM_BSEL_ADDR;
    wire logic        dst_pcl    = dst_addr == {`BDM_PCL_BANK, `BDM_PCL_OFS};               // RL18
    // Upper half of bank 14 holds no user storage; keeps user RAM at 3808 bytes
    wire logic        src_ext    = (src_addr >= `BDM_EXT_LO) && (src_addr <= `BDM_EXT_HI); // RL3
    wire logic        dst_ext    = (dst_addr >= `BDM_EXT_LO) && (dst_addr <= `BDM_EXT_HI); // RL3
    // Control area: the bank selector and program counter low live here; all but the bank selector read zero
    wire logic        src_ctrl   = src_addr >= `BDM_CTRL_BASE;                              // RL19
    wire logic        dst_ctrl   = dst_addr >= `BDM_CTRL_BASE;                              // RL19
    wire logic        src_ram    = (src_addr <= `BDM_RAM_TOP) && !src_ext;                  // RL16 RL4
    wire logic [7:0]  bsel_byte  = {`BDM_HI_NIBBLE, bank_q};                                // RL6
    wire logic [7:0]  rd_byte    = src_bsel ? bsel_byte :
                                   (src_ram ? mem_q[src_addr] : `BDM_ZERO_BYTE);            // RL4
    // Storage write only where memory backs the location
    wire logic        ram_write  = do_write && q_write && bank_impl && !dst_ctrl && !dst_ext; // RL8
    wire logic        bsel_write = do_write && q_write && dst_bsel;
    wire logic [7:0]  wr_byte    = is_move ? rdata_q : req_q.wdata;

    // ------------------------------------------------------------
    // Quadrature phase counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= `BDM_Q_FIRST;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // Latch request at the end of Q4 so the whole cycle sees one operand
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_q <= '0;
            act_q <= 1'b0;
        end else if (q_last) begin
            req_q <= req;
            act_q <= req_valid;
        end
    end

    // ------------------------------------------------------------
    // Bank selector
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_q <= `BDM_BSEL_RST;
        end else if (act_q && is_load && q_write) begin
            bank_q <= req_q.literal[3:0];                                                   // RL7 RL6
        end else if (bsel_write) begin
            bank_q <= wr_byte[3:0];                                                         // RL6
        end
    end

    // ------------------------------------------------------------
    // Operand read in Q2, write back in Q4
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q   <= `BDM_ZERO_BYTE;
            rd_addr_q <= '0;
        end else if (do_access && q_read) begin
            rdata_q   <= rd_byte;                                                           // RL20 RL14
            rd_addr_q <= src_addr;
        end
    end

    // Contents survive every reset
    always_ff @(posedge clk) begin
        if (ram_write) begin
            mem_q[dst_addr] <= wr_byte;                                                     // RL20 RL17
        end
    end

    // ------------------------------------------------------------
    // Completion strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q  <= 1'b0;
            wdone_q <= 1'b0;
            pclw_q  <= 1'b0;
            pcld_q  <= `BDM_ZERO_BYTE;
        end else begin
            stat_q  <= do_write && q_write;                                                 // RL8
            wdone_q <= ram_write;
            pclw_q  <= do_write && q_write && dst_pcl;                                      // RL18
            pcld_q  <= (do_write && q_write && dst_pcl) ? wr_byte : pcld_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata         = rdata_q;
    assign rd_addr       = rd_addr_q;
    assign status_update = stat_q;
    assign write_done    = wdone_q;
    assign pcl_write     = pclw_q;
    assign pcl_data      = pcld_q;
    assign bank_select   = bank_q;
    assign phase         = bdm_pkg::bdm_phase_t'(phase_q);

    wire logic unused_q = q_first ^ src_ctrl;

endmodule

// *** bdm_data_mem_monitor.sv ***
// Assertion checker for the banked data memory block
`timescale 1ns/1ps
module bdm_data_mem_monitor (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire bdm_pkg::bdm_req_t   req,
    input wire logic                req_valid,
    input wire logic                extended_isa_enable,
    input wire logic [7:0]          rdata,
    input wire logic [11:0]         rd_addr,
    input wire logic                status_update,
    input wire logic                write_done,
    input wire logic                pcl_write,
    input wire logic [7:0]          pcl_data,
    input wire logic [3:0]          bank_select,
    input wire bdm_pkg::bdm_phase_t phase
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Capture decode
    // ----------------------------------------
    wire        cap  = req_valid && (phase == bdm_pkg::BDM_PH_Q4);
    wire        fcap = cap && (req.op == bdm_pkg::BDM_OP_FILE);
    wire [11:0] acc  = (req.offset < 8'h60) ? {4'h0, req.offset} : {4'hF, req.offset};
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_phase; phase == bdm_pkg::BDM_PH_Q2 |=> phase == bdm_pkg::BDM_PH_Q3 ##1 phase == bdm_pkg::BDM_PH_Q4
        ##1 phase == bdm_pkg::BDM_PH_Q1 ##1 phase == bdm_pkg::BDM_PH_Q2; endproperty
    a_phase: assert property (p_phase) else $error("phase sequence broken");
    property p_ldbank; cap && req.op == bdm_pkg::BDM_OP_LOADBANK |-> ##5 bank_select == $past(req.literal[3:0], 5);
    endproperty
    a_ldbank: assert property (p_ldbank) else $error("bank literal not loaded");
    property p_banked; fcap && req.access_sel |-> ##3 rd_addr == {bank_select, $past(req.offset, 3)}; endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");
    property p_access; fcap && !req.access_sel |-> ##3 rd_addr == $past(acc, 3); endproperty
    a_access: assert property (p_access) else $error("access map address wrong");
    property p_move; cap && req.op == bdm_pkg::BDM_OP_MOVE |-> ##3 rd_addr == $past(req.src_addr, 3); endproperty
    a_move: assert property (p_move) else $error("move source address wrong");
    property p_zero; fcap && !req.access_sel && req.offset >= 8'h60 && req.offset != 8'hE0 |-> ##3 rdata == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("control area read not zero");
    property p_status; fcap && req.write_en |-> ##[4:6] status_update; endproperty
    a_status: assert property (p_status) else $error("status update missing");
    property p_pcl; pcl_write |-> !write_done && status_update; endproperty
    a_pcl: assert property (p_pcl) else $error("program counter write stored");
    c_ld: cover property (cap && req.op == bdm_pkg::BDM_OP_LOADBANK);
    c_pcl: cover property (pcl_write);
    c_drop: cover property (status_update && !write_done);
endmodule

bind bdm_data_mem bdm_data_mem_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
    .extended_isa_enable(extended_isa_enable), .rdata(rdata), .rd_addr(rd_addr), .status_update(status_update),
    .write_done(write_done), .pcl_write(pcl_write), .pcl_data(pcl_data), .bank_select(bank_select), .phase(phase));

// *** bdm_core_model.sv ***
// Execution pipeline model issuing one request per instruction cycle
`timescale 1ns/1ps
module bdm_core_model (
    input  wire logic                clk,
    input  wire bdm_pkg::bdm_phase_t phase,
    output bdm_pkg::bdm_req_t        req,
    output logic                     req_valid
);
    // Idle request at time zero
    initial begin
        req       = '0;
        req_valid = 1'b0;
    end
    // Present in Q4, withdraw after the capture edge
    task automatic issue(input bdm_pkg::bdm_req_t r);
        @(negedge clk);
        while (phase !== bdm_pkg::BDM_PH_Q4) @(negedge clk);
        req       = r;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        req       = ~r; // Stale fields never linger
    endtask
endmodule

// *** bdm_data_mem_tb.sv ***
// Self-checking bench for the banked data memory block
`timescale 1ns/1ps
module bdm_data_mem_tb;
    logic                clk = 1'b0;
    logic                sys_rst = 1'b1;
    bdm_pkg::bdm_req_t   req;
    logic                req_valid, status_update, write_done, pcl_write;
    logic [7:0]          rdata, pcl_data;
    logic [11:0]         rd_addr;
    logic [3:0]          bank_select;
    bdm_pkg::bdm_phase_t phase;
    int                  miscompares = 0, checks = 0, cycles = 0, n_st = 0, n_wd = 0, n_pc = 0;
    bdm_data_mem dut_u (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .extended_isa_enable(1'b0),
        .rdata(rdata), .rd_addr(rd_addr), .status_update(status_update), .write_done(write_done),
        .pcl_write(pcl_write), .pcl_data(pcl_data), .bank_select(bank_select), .phase(phase));
    bdm_core_model core_u (.clk(clk), .phase(phase), .req(req), .req_valid(req_valid));
    always #4 clk = ~clk;
    // Strobe counters and watchdog
    always @(posedge clk) begin
        n_st <= n_st + int'(status_update === 1'b1);
        n_wd <= n_wd + int'(write_done === 1'b1);
        n_pc <= n_pc + int'(pcl_write === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic bdm_pkg::bdm_req_t mk(bdm_pkg::bdm_op_t op, logic a, logic [7:0] o, logic w, logic [7:0] d);
        mk = '{op, a, o, 12'h000, 12'h000, w, d, d};
    endfunction
    // Issue one request and wait until its operand read has landed
    task automatic run(input bdm_pkg::bdm_req_t r);
        core_u.issue(r);
        repeat (2) @(negedge clk);
    endtask
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic t_bank();
        run(mk(bdm_pkg::BDM_OP_LOADBANK, 1'b0, 8'h00, 1'b0, 8'hA5));
        settle();
        check(bank_select, 12'h005);
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b0, 8'hE0, 1'b0, 8'h00));
        check(rdata, 12'h005);
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b0, 8'hE0, 1'b1, 8'h3C));
        settle();
        check(bank_select, 12'h00C);
    endtask
    task automatic t_map();
        run(mk(bdm_pkg::BDM_OP_LOADBANK, 1'b0, 8'h00, 1'b0, 8'h03));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h42, 1'b1, 8'h5A));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b0, 8'h10, 1'b1, 8'h11));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h10, 1'b1, 8'h22));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h42, 1'b0, 8'h00));
        check(rd_addr, 12'h342);
        check(rdata, 12'h05A);
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b0, 8'h10, 1'b0, 8'h00));
        check(rd_addr, 12'h010);
        check(rdata, 12'h011);
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b0, 8'h5F, 1'b0, 8'h00));
        check(rd_addr, 12'h05F);
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b0, 8'h60, 1'b0, 8'h00));
        check(rd_addr, 12'hF60);
        check(rdata, 12'h000);
    endtask
    task automatic t_move();
        bdm_pkg::bdm_req_t r;
        r = mk(bdm_pkg::BDM_OP_MOVE, 1'b1, 8'h00, 1'b0, 8'h00);
        r.src_addr = 12'h342;
        r.dst_addr = 12'h7FF;
        run(r);
        check(rd_addr, 12'h342);
        run(mk(bdm_pkg::BDM_OP_LOADBANK, 1'b0, 8'h00, 1'b0, 8'h07));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'hFF, 1'b0, 8'h00));
        check(rdata, 12'h05A);
    endtask
    task automatic t_drop();
        int s, w, p;
        run(mk(bdm_pkg::BDM_OP_LOADBANK, 1'b0, 8'h00, 1'b0, 8'h0F));
        settle();
        {s, w, p} = {n_st, n_wd, n_pc};
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h61, 1'b1, 8'h77));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'hF9, 1'b1, 8'h9C));
        settle();
        check(12'(n_st - s), 12'h002);
        check(12'(n_wd - w), 12'h000);
        check(12'(n_pc - p), 12'h001);
        check(pcl_data, 12'h09C);
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h61, 1'b0, 8'h00));
        check(rdata, 12'h000);
        run(mk(bdm_pkg::BDM_OP_LOADBANK, 1'b0, 8'h00, 1'b0, 8'h0E));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h80, 1'b1, 8'h33));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h80, 1'b0, 8'h00));
        check(rd_addr, 12'hE80);
        check(rdata, 12'h000);
    endtask
    task automatic t_keep();
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        check(bank_select, 12'h000);
        sys_rst = 1'b0;
        run(mk(bdm_pkg::BDM_OP_LOADBANK, 1'b0, 8'h00, 1'b0, 8'h03));
        run(mk(bdm_pkg::BDM_OP_FILE, 1'b1, 8'h42, 1'b0, 8'h00));
        check(rdata, 12'h05A);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        t_bank();
        t_map();
        t_move();
        t_drop();
        t_keep();
        complete_run();
    end
endmodule
